// File: bench/i2c_bus_master_model.sv
// behavioural two-wire bus master for the far side of the slave port
// assumes pull-ups on both lines; the bench merges drives into wire levels
`timescale 1ns/1ps
`default_nettype none
module i2c_bus_master_model (
    input wire logic scl_in,
    input wire logic sda_in,
    output var logic scl_rel,
    output var logic sda_rel
);
    int n_stuck = 0;
    initial begin
        scl_rel = 1'b1;
        sda_rel = 1'b1;
    end
    // a stretch that never ends is counted, not hung on
    task automatic wait_high();
        int n;
        n = 0;
        while (scl_in !== 1'b1 && n < 4000) begin
            #100;
            n++;
        end
        if (n == 4000) n_stuck++;
    endtask : wait_high
    // 800 ns bit: 600 ns low covers the slave's sync lag, 200 ns high
    task automatic bit_io(input logic b, output logic s);
        sda_rel = b;
        #500;
        scl_rel = 1'b1;
        wait_high();
        #100;
        s = sda_in;
        #100;
        scl_rel = 1'b0;
        #100;
    endtask : bit_io
    task automatic start();
        // step off the hclk edge so pin changes never race it
        #25;
        sda_rel = 1'b1;
        #200;
        scl_rel = 1'b1;
        wait_high();
        #400;
        sda_rel = 1'b0;
        #400;
        scl_rel = 1'b0;
        #200;
    endtask : start
    task automatic stop();
        #25;
        sda_rel = 1'b0;
        #200;
        scl_rel = 1'b1;
        wait_high();
        #400;
        sda_rel = 1'b1;
        #400;
    endtask : stop
    task automatic put_byte(input logic [7:0] d, output logic nack);
        logic s;
        #25;
        for (int i = 7; i >= 0; i--) bit_io(d[i], s);
        bit_io(1'b1, nack);
        #800;
    endtask : put_byte
    task automatic get_byte(input logic nack, output logic [7:0] d);
        logic s;
        #25;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, s);
            d[i] = s;
        end
        bit_io(nack, s);
        #800;
    endtask : get_byte
endmodule : i2c_bus_master_model
`default_nettype wire

// File: bench/tb_i2c_slave_port_control.sv
// self-checking bench for the two-wire slave port
// assumes the port answers ahb-lite with no wait states; master model on pins
`timescale 1ns/1ps
`default_nettype none
module tb_i2c_slave_port_control;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0000_0000;
    wire logic [31:0] hrdata;
    wire logic hreadyout, hresp, scl_oe_n, sda_oe_n, scl_out, sda_out;
    wire logic slew_control_off, irq, m_scl_rel, m_sda_rel;
    wire logic scl_wire = m_scl_rel & (scl_oe_n | scl_out);
    wire logic sda_wire = m_sda_rel & (sda_oe_n | sda_out);
    i2c_slave_pkg::bus_pins_t pins;
    int n_mismatch = 0;
    int cmp_count = 0;
    int n_irq = 0;
    int n_stray = 0;
    logic quiet = 1'b0;
    assign pins = {scl_wire, sda_wire};
    always #50 hclk = ~hclk;
    always @(posedge hclk) if (irq === 1'b1) n_irq <= n_irq + 1;
    always @(posedge hclk) begin
        if (quiet && (scl_oe_n !== 1'b1 || sda_oe_n !== 1'b1)) n_stray++;
    end
    i2c_slave_port u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .pins_in(pins),
        .scl_oe_n(scl_oe_n), .sda_oe_n(sda_oe_n), .scl_out(scl_out),
        .sda_out(sda_out), .slew_control_off(slew_control_off), .irq(irq));
    i2c_bus_master_model u_master (.scl_in(scl_wire), .sda_in(sda_wire),
        .scl_rel(m_scl_rel), .sda_rel(m_sda_rel));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // read data taken at the data-phase edge, before the slave moves on
    task automatic xfer(input logic [7:0] a, input logic wr,
                        input logic [31:0] wd, output logic [31:0] rd);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {24'h00_0000, a};
        htrans <= 2'h2;
        hwrite <= wr;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : xfer
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] x;
        xfer(a, 1'b1, d, x);
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        xfer(a, 1'b0, 32'h0000_0000, d);
    endtask : rd
    task automatic t_reset_values();
        logic [31:0] d;
        logic [7:0] a [7] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h20};
        logic [31:0] e [7] = '{32'h0000_0000, 32'h0000_0000, 32'h0000_0010,
            32'h0000_0044, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000};
        for (int i = 0; i < 7; i++) begin
            rd(a[i], d);
            chk(d, e[i]);
        end
        wr(i2c_slave_pkg::ADDR_OWN, 32'hFFFF_FFA4);
        rd(i2c_slave_pkg::ADDR_OWN, d);
        chk(d, 32'h0000_00A4);
    endtask : t_reset_values
    task automatic t_off();
        logic nk;
        wr(i2c_slave_pkg::ADDR_CFG, 32'h0000_0000);
        wr(i2c_slave_pkg::ADDR_CFG, 32'h0000_0002);
        @(posedge hclk);
        chk({31'h0000_0000, slew_control_off}, 32'h0000_0001);
        for (int k = 0; k < 2; k++) begin
            wr(i2c_slave_pkg::ADDR_GATES, k == 0 ? 32'h0 : 32'h0000_0100);
            wr(i2c_slave_pkg::ADDR_CFG, k == 0 ? 32'h5 : 32'h0000_0004);
            quiet = 1'b1;
            u_master.start();
            u_master.put_byte(8'hA4, nk);
            chk({31'h0000_0000, nk}, 32'h0000_0001);
            u_master.stop();
            quiet = 1'b0;
        end
        chk(32'(n_stray), 32'h0000_0000);
        chk({31'h0000_0000, slew_control_off}, 32'h0000_0000);
    endtask : t_off
    task automatic t_write();
        logic nk;
        logic [31:0] d;
        int n0;
        wr(i2c_slave_pkg::ADDR_CFG, 32'h0000_0005);
        u_master.start();
        u_master.put_byte(8'hA4, nk);
        chk({31'h0000_0000, nk}, 32'h0000_0000);
        rd(i2c_slave_pkg::ADDR_STAT, d);
        chk(d & 32'h0000_0004, 32'h0000_0000);
        n0 = n_irq;
        u_master.put_byte(8'h3C, nk);
        chk(32'(n_irq - n0), 32'h0000_0001);
        rd(i2c_slave_pkg::ADDR_STAT, d);
        chk(d & 32'h0000_0008, 32'h0000_0008);
        u_master.put_byte(8'h99, nk);
        chk({31'h0000_0000, nk}, 32'h0000_0001);
        rd(i2c_slave_pkg::ADDR_STAT, d);
        chk(d & 32'h0000_0001, 32'h0000_0001);
        rd(i2c_slave_pkg::ADDR_DATA, d);
        chk(d, 32'h0000_003C);
        rd(i2c_slave_pkg::ADDR_STAT, d);
        chk(d & 32'h0000_0008, 32'h0000_0000);
        wr(i2c_slave_pkg::ADDR_STAT, 32'h0000_0000);
        rd(i2c_slave_pkg::ADDR_STAT, d);
        chk(d & 32'h0000_0001, 32'h0000_0000);
        u_master.stop();
    endtask : t_write
    task automatic t_read();
        logic nk;
        logic [7:0] b;
        logic [31:0] d;
        wr(i2c_slave_pkg::ADDR_STAGE, 32'h0000_00C6);
        u_master.start();
        u_master.put_byte(8'hA5, nk);
        chk({31'h0000_0000, nk}, 32'h0000_0000);
        wr(i2c_slave_pkg::ADDR_STAGE, 32'h0000_005A);
        u_master.get_byte(1'b0, b);
        chk({24'h00_0000, b}, 32'h0000_00C6);
        rd(i2c_slave_pkg::ADDR_STAT, d);
        chk(d & 32'h0000_0008, 32'h0000_0008);
        u_master.get_byte(1'b1, b);
        chk({24'h00_0000, b}, 32'h0000_005A);
        rd(i2c_slave_pkg::ADDR_STAT, d);
        chk(d & 32'h0000_000C, 32'h0000_0004);
        u_master.stop();
    endtask : t_read
    task automatic t_rd_stretch();
        logic nk;
        logic [7:0] b;
        logic [31:0] d, d0;
        wr(i2c_slave_pkg::ADDR_CFG, 32'h0000_0015);
        rd(i2c_slave_pkg::ADDR_DATA, d0);
        wr(i2c_slave_pkg::ADDR_DATA, 32'h0000_0055);
        rd(i2c_slave_pkg::ADDR_DATA, d);
        chk(d, d0);
        rd(i2c_slave_pkg::ADDR_STAT, d);
        chk(d & 32'h0000_0002, 32'h0000_0002);
        wr(i2c_slave_pkg::ADDR_CFG, 32'h0000_0035);
        rd(i2c_slave_pkg::ADDR_STAT, d);
        chk(d, 32'h0000_0044);
        wr(i2c_slave_pkg::ADDR_CFG, 32'h0000_0015);
        wr(i2c_slave_pkg::ADDR_OWN, 32'h0000_00A4);
        u_master.start();
        u_master.put_byte(8'hA5, nk);
        rd(i2c_slave_pkg::ADDR_CFG, d);
        chk(d & 32'h0000_0004, 32'h0000_0000);
        chk({31'h0000_0000, scl_oe_n}, 32'h0000_0000);
        wr(i2c_slave_pkg::ADDR_DATA, 32'h0000_00E1);
        rd(i2c_slave_pkg::ADDR_STAT, d);
        chk(d & 32'h0000_000A, 32'h0000_0008);
        wr(i2c_slave_pkg::ADDR_CFG, 32'h0000_0015);
        u_master.get_byte(1'b1, b);
        chk({24'h00_0000, b}, 32'h0000_00E1);
        u_master.stop();
    endtask : t_rd_stretch
    task automatic t_wr_stretch();
        logic nk;
        logic [31:0] d;
        wr(i2c_slave_pkg::ADDR_CFG, 32'h0000_000D);
        u_master.start();
        u_master.put_byte(8'hA4, nk);
        rd(i2c_slave_pkg::ADDR_CFG, d);
        if (d[2] !== 1'b1) wr(i2c_slave_pkg::ADDR_CFG, 32'h0000_000D);
        u_master.put_byte(8'h77, nk);
        rd(i2c_slave_pkg::ADDR_CFG, d);
        chk(d & 32'h0000_0004, 32'h0000_0000);
        chk({31'h0000_0000, scl_oe_n}, 32'h0000_0000);
        rd(i2c_slave_pkg::ADDR_DATA, d);
        chk(d, 32'h0000_0077);
        wr(i2c_slave_pkg::ADDR_CFG, 32'h0000_0005);
        u_master.stop();
    endtask : t_wr_stretch
    task automatic give_verdict();
        if (n_mismatch == 0 && cmp_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : give_verdict
    initial begin
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        t_reset_values();
        t_off();
        t_write();
        t_read();
        t_rd_stretch();
        t_wr_stretch();
        chk(32'(u_master.n_stuck), 32'h0000_0000);
        give_verdict();
    end
    // about a dozen 8 us bytes plus register traffic; 3 ms is ample margin
    initial begin
        #3_000_000;
        n_mismatch++;
        give_verdict();
    end
endmodule : tb_i2c_slave_port_control
`default_nettype wire

// File: hdl/i2c_slave_pkg.sv
// constants, register map and carrier types for the two-wire slave port
// assumes an ahb-lite master and a 10 mhz hclk
package i2c_slave_pkg;
    localparam logic [7:0] ADDR_OWN = 8'h00;
    localparam logic [7:0] ADDR_DATA = 8'h04;
    localparam logic [7:0] ADDR_CFG = 8'h08;
    localparam logic [7:0] ADDR_STAT = 8'h0C;
    localparam logic [7:0] ADDR_STAGE = 8'h10;
    localparam logic [7:0] ADDR_GATES = 8'h14;
    localparam int GATE_BIT = 8;
    localparam logic [31:0] GATES_RESET = 32'h0000_0000;
    localparam logic [5:0] CFG_RESET = 6'h10;
    localparam logic [7:0] STAT_RESET = 8'h44;
    localparam int CFG_EN = 0;
    localparam int CFG_SLEW = 1;
    localparam int CFG_REL = 2;
    localparam int CFG_WRS = 3;
    localparam int CFG_RDS = 4;
    localparam int CFG_RST = 5;
    localparam int ST_START = 7;
    localparam int ST_STOP = 6;
    localparam int ST_RW = 5;
    localparam int ST_AD = 4;
    localparam int ST_BF = 3;
    localparam int ST_NACK = 2;
    localparam int ST_WRITE_COLLISION_FLAG = 1;
    localparam int ST_OVR = 0;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [3:0] ACK_CLOCK = 4'h9;
    typedef struct packed {
        logic scl;
        logic sda;
    } bus_pins_t;
endpackage : i2c_slave_pkg

// File: hdl/i2c_slave_port.sv
// two-wire slave port with ahb-lite register access
// assumes the bus master drives scl; pins sampled in hclk domain
// What this block does
// RULE1: module runs only while clock gate set
// RULE2: transmit data buffer msb first, eight clocks
// RULE3: receive byte after eight, interrupt after ninth
// RULE4: read-stretch writes need direction one, release zero
// RULE5: no read stretch: staging buffer loads transmitter
// RULE6: software preloads staging buffer each interrupt
// RULE7: config bit five resets whole serial module; cfg and shreg keep their values
// RULE8: software clears module reset before configuring
// RULE9: port disabled means no bus effect
// RULE10: config bit one drives slew control pad
// RULE11: release bit zero holds clock low
// RULE12: write stretch clears release at receive interrupt
// RULE13: write stretch off only for fast service
// RULE14: read stretch clears release after address/ack
// RULE15: software disables stretching before last byte
// RULE16: config resets to read stretch only
// RULE17: status layout, resets with stop and nack
// RULE18: own address in low eight bits
// RULE19: ninth rising edge samples ack; start clears
// RULE20: byte while full sets overrun, discarded
// RULE21: buffer read or transmit end clears full
// RULE22: reserved bits read zero, writes ignored; the gates register stores and reads back all 32 bits written to it
//
// The AHB-Lite interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module i2c_slave_port (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire i2c_slave_pkg::bus_pins_t pins_in,
    output logic scl_oe_n,
    output logic sda_oe_n,
    output logic scl_out,
    output logic sda_out,
    output logic slew_control_off,
    output logic irq
);
    // ahb address phase capture
    logic ph_wr;
    logic ph_rd;
    logic [7:0] ph_addr;
    wire take = hsel && hready && htrans[1];
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ph_wr <= 1'b0;
            ph_rd <= 1'b0;
            ph_addr <= 8'h00;
        end else begin
            ph_wr <= take && hwrite;
            ph_rd <= take && !hwrite;
            ph_addr <= haddr[7:0];
        end
    end
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    wire wr_own = ph_wr && ph_addr == i2c_slave_pkg::ADDR_OWN;
    wire wr_data = ph_wr && ph_addr == i2c_slave_pkg::ADDR_DATA;
    wire wr_cfg = ph_wr && ph_addr == i2c_slave_pkg::ADDR_CFG;
    wire wr_stat = ph_wr && ph_addr == i2c_slave_pkg::ADDR_STAT;
    wire wr_stage = ph_wr && ph_addr == i2c_slave_pkg::ADDR_STAGE;
    wire wr_gates = ph_wr && ph_addr == i2c_slave_pkg::ADDR_GATES;
    wire rd_data = ph_rd && ph_addr == i2c_slave_pkg::ADDR_DATA;

    // gate register lives outside the serial module reset
    logic [31:0] gates;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) gates <= i2c_slave_pkg::GATES_RESET;
        else if (wr_gates) gates <= hwdata;
    end
    wire gate_on = gates[i2c_slave_pkg::GATE_BIT]; // RULE1

    // pin synchronisers: three stages, second and third must agree
    logic [2:0] scl_sy;
    logic [2:0] sda_sy;
    logic scl_q;
    logic sda_q;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            scl_sy <= 3'h7;
            sda_sy <= 3'h7;
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_sy <= {scl_sy[1:0], pins_in.scl};
            sda_sy <= {sda_sy[1:0], pins_in.sda};
            if (scl_sy[1] == scl_sy[2]) scl_q <= scl_sy[2];
            if (sda_sy[1] == sda_sy[2]) sda_q <= sda_sy[2];
        end
    end
    logic scl_d;
    logic sda_d;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            scl_d <= 1'b1;
            sda_d <= 1'b1;
        end else begin
            scl_d <= scl_q;
            sda_d <= sda_q;
        end
    end
    wire scl_rise = scl_q && !scl_d;
    wire scl_fall = !scl_q && scl_d;
    wire start_ev = scl_q && scl_d && sda_d && !sda_q;
    wire stop_ev = scl_q && scl_d && !sda_d && sda_q;

    // serial module registers, reset by module reset except cfg and shreg, which keep their values
    logic [5:0] cfg;
    logic [7:0] own;
    logic [7:0] dbuf;
    logic [7:0] stage;
    logic [7:0] shreg;
    logic [3:0] cnt;
    logic active;
    logic addr_phase;
    logic tx_mode;
    logic drive_sda;
    logic st_start, st_stop, st_rw, st_ad, st_bf, st_nack, st_write_collision_flag, st_ovr;
    wire mod_rst = cfg[i2c_slave_pkg::CFG_RST]; // RULE7
    wire run = gate_on && !mod_rst && cfg[i2c_slave_pkg::CFG_EN]; // RULE1
    wire rds = cfg[i2c_slave_pkg::CFG_RDS];
    wire wrs = cfg[i2c_slave_pkg::CFG_WRS];
    wire release_bit = cfg[i2c_slave_pkg::CFG_REL];
    wire wr_ok = !rds || (st_rw && !release_bit); // RULE4
    wire bus_ev = run && active;
    wire fall8 = bus_ev && scl_fall && cnt == i2c_slave_pkg::BITS_PER_BYTE;
    wire rise9 = bus_ev && scl_rise && cnt == i2c_slave_pkg::BITS_PER_BYTE;
    wire fall9 = bus_ev && scl_fall && cnt == i2c_slave_pkg::ACK_CLOCK;
    wire addr_hit = addr_phase && shreg[7:1] == own[7:1];
    wire rx_byte = fall8 && !addr_phase && !tx_mode;
    wire addr_rd = fall9 && addr_phase && addr_hit && shreg[0];
    wire tx_acked = fall9 && tx_mode && !st_nack;
    wire load_next = addr_rd || tx_acked;
    wire rx_irq = fall9 && !tx_mode && (!addr_phase || addr_hit);
    wire [7:0] next_byte = rds ? dbuf : stage; // RULE5

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cfg <= i2c_slave_pkg::CFG_RESET; // RULE16
        end else if (wr_cfg) begin
            cfg <= hwdata[5:0]; // RULE22 RULE8 RULE15
        end else if (mod_rst) begin
            cfg <= cfg;
        end else if ((rx_irq && wrs) || (load_next && rds)) begin
            cfg[i2c_slave_pkg::CFG_REL] <= 1'b0; // RULE12 RULE13 RULE14
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            own <= 8'h00;
            stage <= 8'h00;
        end else if (mod_rst) begin
            own <= 8'h00;
            stage <= 8'h00;
        end else begin
            if (wr_own) own <= hwdata[7:0]; // RULE18
            if (wr_stage) stage <= hwdata[7:0]; // RULE6
        end
    end

    // bit engine
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt <= 4'h0;
            active <= 1'b0;
            addr_phase <= 1'b0;
            tx_mode <= 1'b0;
            shreg <= 8'h00;
            drive_sda <= 1'b0;
        end else if (mod_rst || !run || stop_ev) begin
            cnt <= 4'h0;
            active <= 1'b0;
            addr_phase <= 1'b0;
            tx_mode <= 1'b0;
            drive_sda <= 1'b0;
        end else if (start_ev) begin
            cnt <= 4'h0;
            active <= 1'b1;
            addr_phase <= 1'b1;
            tx_mode <= 1'b0;
            drive_sda <= 1'b0;
        end else if (active) begin
            // a read-stretch write lands while scl is held: reload shifter
            if (wr_data && wr_ok && rds && tx_mode && cnt == 4'h0) begin
                shreg <= {hwdata[6:0], 1'b0}; // RULE14
                drive_sda <= !hwdata[7]; // RULE2
            end
            if (scl_rise && cnt < i2c_slave_pkg::BITS_PER_BYTE && !tx_mode)
                shreg <= {shreg[6:0], sda_q};
            if (scl_rise)
                cnt <= cnt + 4'h1;
            if (fall8) begin
                // ack the address or a received byte; nack on overrun
                drive_sda <= !tx_mode && (addr_phase ? addr_hit : !st_bf);
            end else if (fall9) begin
                cnt <= 4'h0;
                addr_phase <= 1'b0;
                if (addr_phase && !addr_hit) active <= 1'b0;
                if (load_next) begin
                    tx_mode <= 1'b1;
                    shreg <= {next_byte[6:0], 1'b0}; // RULE2
                    drive_sda <= !next_byte[7]; // RULE2
                end else begin
                    tx_mode <= tx_mode && !st_nack && !addr_phase;
                    drive_sda <= 1'b0;
                end
            end else if (scl_fall && tx_mode && cnt < 4'h8) begin
                drive_sda <= !shreg[7]; // RULE2
                shreg <= {shreg[6:0], 1'b0};
            end
        end
    end

    // data buffer and status flags
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dbuf <= 8'h00;
        end else if (mod_rst) begin
            dbuf <= 8'h00;
        end else if (wr_data && wr_ok) begin
            dbuf <= hwdata[7:0]; // RULE4
        end else if (load_next && !rds) begin
            dbuf <= stage; // RULE5
        end else if (rx_byte && !st_bf) begin
            dbuf <= shreg; // RULE3 RULE20
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            {st_start, st_stop, st_rw, st_ad, st_bf, st_nack, st_write_collision_flag, st_ovr}
                <= i2c_slave_pkg::STAT_RESET; // RULE17
        end else if (mod_rst) begin
            {st_start, st_stop, st_rw, st_ad, st_bf, st_nack, st_write_collision_flag, st_ovr}
                <= i2c_slave_pkg::STAT_RESET;
        end else begin
            if (wr_stat && !hwdata[i2c_slave_pkg::ST_WRITE_COLLISION_FLAG])
                st_write_collision_flag <= 1'b0;
            if (wr_stat && !hwdata[i2c_slave_pkg::ST_OVR])
                st_ovr <= 1'b0;
            if (wr_data && !wr_ok) st_write_collision_flag <= 1'b1; // RULE4
            if (rx_byte && st_bf) st_ovr <= 1'b1; // RULE20
            // set wins over a read in the same cycle
            if (rd_data) st_bf <= 1'b0; // RULE21
            if (fall8 && tx_mode) st_bf <= 1'b0; // RULE21
            if ((wr_data && wr_ok) || (load_next && !rds)) st_bf <= 1'b1;
            if (rx_byte) st_bf <= 1'b1; // RULE3
            if (fall8) st_ad <= !addr_phase;
            if (rise9) st_nack <= sda_q; // RULE19
            if (fall9 && addr_phase && addr_hit) st_rw <= shreg[0];
            if (fall9 && st_nack) st_rw <= 1'b0;
            if (run && start_ev) begin
                st_start <= 1'b1;
                st_stop <= 1'b0;
                st_nack <= 1'b0; // RULE19
                st_rw <= 1'b0;
            end
            if (run && stop_ev) begin
                st_start <= 1'b0;
                st_stop <= 1'b1;
                st_rw <= 1'b0;
            end
        end
    end

    // receive and transmit interrupt pulse after the ninth clock
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) irq <= 1'b0;
        else irq <= rx_irq || (fall9 && tx_mode); // RULE3
    end

    // pin drive: active low enables, wire level resolved outside
    assign scl_out = 1'b0;
    assign sda_out = 1'b0;
    assign scl_oe_n = !(run && !release_bit); // RULE9 RULE11
    assign sda_oe_n = !(run && drive_sda); // RULE9
    assign slew_control_off = cfg[i2c_slave_pkg::CFG_SLEW]; // RULE10

    // register read mux
    wire [7:0] stat_v = {st_start, st_stop, st_rw, st_ad,
                         st_bf, st_nack, st_write_collision_flag, st_ovr};
    wire [7:0] rd_mux =
        ph_addr == i2c_slave_pkg::ADDR_OWN ? own :
        ph_addr == i2c_slave_pkg::ADDR_DATA ? dbuf :
        ph_addr == i2c_slave_pkg::ADDR_CFG ? {2'b00, cfg} :
        ph_addr == i2c_slave_pkg::ADDR_STAT ? stat_v :
        ph_addr == i2c_slave_pkg::ADDR_STAGE ? stage : 8'h00;
    wire gate_rd = ph_addr == i2c_slave_pkg::ADDR_GATES;
    assign hrdata = !ph_rd ? 32'h0000_0000 :
                    gate_rd ? gates : {24'h00_0000, rd_mux}; // RULE22

    // assertions
    property p_write_collision_flag_on_bad_write;
        @(posedge hclk) disable iff (!hresetn)
        (wr_data && !wr_ok && !mod_rst) |=> st_write_collision_flag && $stable(dbuf);
    endproperty
    a_write_collision_flag_on_bad_write: assert property (p_write_collision_flag_on_bad_write) // RULE4
        else $error("blocked data write not flagged");
    property p_overrun;
        @(posedge hclk) disable iff (!hresetn)
        (rx_byte && st_bf && !mod_rst) |=> st_ovr && $stable(dbuf);
    endproperty
    a_overrun: assert property (p_overrun) // RULE20
        else $error("overrun not flagged");
    property p_rx_store;
        @(posedge hclk) disable iff (!hresetn)
        (rx_byte && !st_bf && !mod_rst) |=> st_bf && dbuf == $past(shreg);
    endproperty
    a_rx_store: assert property (p_rx_store) // RULE3
        else $error("received byte not stored");
    property p_irq_ninth;
        @(posedge hclk) disable iff (!hresetn)
        rx_irq |=> irq;
    endproperty
    a_irq_ninth: assert property (p_irq_ninth) // RULE3
        else $error("no interrupt after ninth clock");
    property p_disabled_quiet;
        @(posedge hclk) disable iff (!hresetn)
        !run |-> scl_oe_n && sda_oe_n;
    endproperty
    a_disabled_quiet: assert property (p_disabled_quiet) // RULE9
        else $error("disabled port touches the bus");
    property p_hold_low;
        @(posedge hclk) disable iff (!hresetn)
        (run && !release_bit) |-> !scl_oe_n;
    endproperty
    a_hold_low: assert property (p_hold_low) // RULE11
        else $error("clock not held low");
    property p_rd_stretch;
        @(posedge hclk) disable iff (!hresetn)
        (load_next && rds && !wr_cfg && !mod_rst) |=> !release_bit;
    endproperty
    a_rd_stretch: assert property (p_rd_stretch) // RULE14
        else $error("read stretch did not hold clock");
    property p_wr_stretch;
        @(posedge hclk) disable iff (!hresetn)
        (rx_irq && wrs && !wr_cfg && !mod_rst) |=> !release_bit;
    endproperty
    a_wr_stretch: assert property (p_wr_stretch) // RULE12
        else $error("write stretch did not hold clock");
    property p_stage_load;
        @(posedge hclk) disable iff (!hresetn)
        (load_next && !rds && !wr_data && !mod_rst) |=> dbuf == $past(stage);
    endproperty
    a_stage_load: assert property (p_stage_load) // RULE5
        else $error("staging buffer not loaded");
    property p_read_clears_full;
        @(posedge hclk) disable iff (!hresetn)
        (rd_data && !rx_byte && !load_next && !mod_rst) |=> !st_bf;
    endproperty
    a_read_clears_full: assert property (p_read_clears_full) // RULE21
        else $error("read did not clear full flag");
    c_rx: cover property (@(posedge hclk) rx_byte);
    c_tx: cover property (@(posedge hclk) load_next);
    c_write_collision_flag: cover property (@(posedge hclk) wr_data && !wr_ok);
endmodule : i2c_slave_port
`default_nettype wire
